// [rtl/dpdc_config_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module dpdc_config_regs (
	input wire logic clk,
	input wire logic sys_rst,
	input wire dpdc_pkg::dpdc_req_s regReq,
	output dpdc_pkg::dpdc_rsp_s regRsp,
	input wire logic [dpdc_pkg::FEEDBACK_W-1:0] feedbackCount,
	input wire logic referenceIn,
	output dpdc_pkg::dpdc_pll_s pllConfig,
	output logic referenceOut,
	output logic averagedCalStart,
	output logic averagedCalEnable
);
	import dpdc_pkg::*;

	logic [PUMP_W-1:0] pumpCurrentCode;
	logic [OSC_W-1:0] oscDivideSelect;
	logic [REF_W-1:0] referenceDivideRatio;
	logic averagedCalTrigger;
	logic calEnable;
	logic [PUMP_W-1:0] next_pumpCurrentCode;
	logic [OSC_W-1:0] next_oscDivideSelect;
	logic [REF_W-1:0] next_referenceDivideRatio;
	logic next_averagedCalTrigger;
	logic next_calEnable;
	logic next_calStart;
	logic calStart;

	// Register writes
	always_comb begin
		next_pumpCurrentCode = pumpCurrentCode;
		next_oscDivideSelect = oscDivideSelect;
		next_referenceDivideRatio = referenceDivideRatio;
		next_averagedCalTrigger = averagedCalTrigger;
		next_calEnable = calEnable;
		next_calStart = 1'b0;
		if (regReq.wrEn) begin
			case (regReq.addr)
				PUMP_OFFSET: begin
					// Upper bits dropped
					next_pumpCurrentCode = regReq.wrData[PUMP_POS +: PUMP_W];
				end
				OSC_OFFSET: begin
					next_oscDivideSelect = regReq.wrData[OSC_POS +: OSC_W];
				end
				REF_OFFSET: begin
					next_referenceDivideRatio = regReq.wrData[REF_POS +: REF_W];
				end
				CAL_OFFSET: begin
					next_calEnable = regReq.wrData[CAL_ENABLE_POS];
					next_averagedCalTrigger = regReq.wrData[CAL_TRIGGER_POS];
					// Only a 0 to 1 change starts; rewriting 1 does nothing
					next_calStart = regReq.wrData[CAL_TRIGGER_POS] &&
						!averagedCalTrigger;
				end
				default: begin
					next_calStart = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pumpCurrentCode <= PUMP_RESET;
			oscDivideSelect <= OSC_RESET;
			referenceDivideRatio <= REF_RESET;
			averagedCalTrigger <= CAL_TRIGGER_RESET;
			calEnable <= CAL_ENABLE_RESET;
			calStart <= 1'b0;
		end else begin
			pumpCurrentCode <= next_pumpCurrentCode;
			oscDivideSelect <= next_oscDivideSelect;
			referenceDivideRatio <= next_referenceDivideRatio;
			averagedCalTrigger <= next_averagedCalTrigger;
			calEnable <= next_calEnable;
			calStart <= next_calStart;
		end
	end

	assign averagedCalStart = calStart;
	// Enable is only passed through; sequencing it is software's job
	assign averagedCalEnable = calEnable;

	// Register reads
	dpdc_rsp_s next_regRsp;

	always_comb begin
		next_regRsp = '0;
		if (regReq.rdEn) begin
			next_regRsp.rdValid = 1'b1;
			case (regReq.addr)
				PUMP_OFFSET: begin
					next_regRsp.rdData[PUMP_POS +: PUMP_W] = pumpCurrentCode;
				end
				OSC_OFFSET: begin
					next_regRsp.rdData[OSC_POS +: OSC_W] = oscDivideSelect;
				end
				REF_OFFSET: begin
					next_regRsp.rdData[REF_POS +: REF_W] = referenceDivideRatio;
				end
				CAL_OFFSET: begin
					next_regRsp.rdData[CAL_ENABLE_POS] = calEnable;
					next_regRsp.rdData[CAL_TRIGGER_POS] = averagedCalTrigger;
				end
				default: begin
					// Unmapped addresses answer zero
					next_regRsp.rdData = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRsp <= '0;
		end else begin
			regRsp <= next_regRsp;
		end
	end

	// Ratio decoding and multiplier words
	dpdc_pll_s next_pllConfig;
	logic [RATIO_W-1:0] refRatio;

	always_comb begin
		next_pllConfig = '0;
		next_pllConfig.pumpCurrentCode = pumpCurrentCode;
		case (oscDivideSelect)
			OSC_CODE_DIV4: begin
				next_pllConfig.oscDivideRatio = RATIO_W'(4);
			end
			OSC_CODE_DIV8: begin
				next_pllConfig.oscDivideRatio = RATIO_W'(8);
			end
			OSC_CODE_DIV16: begin
				next_pllConfig.oscDivideRatio = RATIO_W'(16);
			end
			default: begin
				// Code 00 has no ratio; flagged, and the oscillator multiple drops to zero
				next_pllConfig.oscDivideRatio = '0;
				next_pllConfig.oscDivideInvalid = 1'b1;
			end
		endcase
		if (referenceDivideRatio <= REF_CODE_MAX) begin
			next_pllConfig.referenceDivideRatio =
				RATIO_W'(1) << referenceDivideRatio;
		end else begin
			next_pllConfig.referenceDivideRatio = RATIO_W'(1);
			next_pllConfig.referenceDivideInvalid = 1'b1;
		end
		next_pllConfig.converterMultiple =
			MULT_W'({feedbackCount, 1'b0});
		// Operands widened first so the product cannot wrap at 9 bits
		next_pllConfig.oscillatorMultiple =
			MULT_W'({feedbackCount, 1'b0}) *
			MULT_W'(next_pllConfig.oscDivideRatio);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pllConfig <= '0;
		end else begin
			pllConfig <= next_pllConfig;
		end
	end

	always_comb begin
		refRatio = pllConfig.referenceDivideRatio;
	end

	// Reference path divider on the sampled input level
	dpdc_edge_divider #(
		.RATIO_W(RATIO_W)
	) u_refDivider (
		.clk(clk),
		.sys_rst(sys_rst),
		.sigIn(referenceIn),
		.ratio(refRatio),
		.sigOut(referenceOut)
	);
endmodule : dpdc_config_regs
`default_nettype wire

// [rtl/dpdc_edge_divider.sv]
`timescale 1ns/10ps
`default_nettype none
module dpdc_edge_divider #(
	parameter int RATIO_W = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sigIn,
	input wire logic [RATIO_W-1:0] ratio,
	output logic sigOut
);
	logic prevIn;
	logic [RATIO_W-1:0] edgeCount;
	logic next_prevIn;
	logic [RATIO_W-1:0] next_edgeCount;
	logic next_sigOut;
	logic [RATIO_W-1:0] halfRatio;

	// Toggling every half ratio of rising edges gives a square wave
	always_comb begin
		halfRatio = ratio >> 1;
		next_prevIn = sigIn;
		next_edgeCount = edgeCount;
		next_sigOut = sigOut;
		if (ratio <= RATIO_W'(1)) begin
			next_edgeCount = '0;
			next_sigOut = sigIn;
		end else if (sigIn && !prevIn) begin
			// Wrap on >= so a ratio lowered mid-count cannot stall
			if (edgeCount >= halfRatio - RATIO_W'(1)) begin
				next_edgeCount = '0;
				next_sigOut = !sigOut;
			end else begin
				next_edgeCount = edgeCount + RATIO_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prevIn <= 1'b0;
			edgeCount <= '0;
			sigOut <= 1'b0;
		end else begin
			prevIn <= next_prevIn;
			edgeCount <= next_edgeCount;
			sigOut <= next_sigOut;
		end
	end
endmodule : dpdc_edge_divider
`default_nettype wire

// [rtl/dpdc_pkg.sv]
package dpdc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int RATIO_W = 5;
	localparam int FEEDBACK_W = 8;
	localparam int MULT_W = 14;

	localparam logic [ADDR_W-1:0] PUMP_OFFSET = 12'h08A;
	localparam logic [ADDR_W-1:0] OSC_OFFSET = 12'h08B;
	localparam logic [ADDR_W-1:0] REF_OFFSET = 12'h08C;
	localparam logic [ADDR_W-1:0] CAL_OFFSET = 12'h0E2;

	localparam int PUMP_POS = 0;
	localparam int PUMP_W = 6;
	localparam int OSC_POS = 0;
	localparam int OSC_W = 2;
	localparam int REF_POS = 0;
	localparam int REF_W = 3;
	localparam int CAL_ENABLE_POS = 0;
	localparam int CAL_TRIGGER_POS = 1;

	localparam logic [PUMP_W-1:0] PUMP_RESET = 6'h20;
	localparam logic [OSC_W-1:0] OSC_RESET = 2'h2;
	localparam logic [REF_W-1:0] REF_RESET = 3'h1;
	localparam logic CAL_ENABLE_RESET = 1'h0;
	localparam logic CAL_TRIGGER_RESET = 1'h0;

	localparam logic [OSC_W-1:0] OSC_CODE_DIV4 = 2'h1;
	localparam logic [OSC_W-1:0] OSC_CODE_DIV8 = 2'h2;
	localparam logic [OSC_W-1:0] OSC_CODE_DIV16 = 2'h3;
	localparam logic [REF_W-1:0] REF_CODE_MAX = 3'h4;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
	} dpdc_req_s;

	typedef struct packed {
		logic rdValid;
		logic [DATA_W-1:0] rdData;
	} dpdc_rsp_s;

	typedef struct packed {
		logic [PUMP_W-1:0] pumpCurrentCode;
		logic [RATIO_W-1:0] oscDivideRatio;
		logic oscDivideInvalid;
		logic [RATIO_W-1:0] referenceDivideRatio;
		logic referenceDivideInvalid;
		logic [MULT_W-1:0] converterMultiple;
		logic [MULT_W-1:0] oscillatorMultiple;
	} dpdc_pll_s;
endpackage : dpdc_pkg

// [tb/dpdc_config_regs_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module dpdc_config_regs_bench;
	import dpdc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	dpdc_req_s regReq = '0;
	dpdc_rsp_s regRsp;
	logic [FEEDBACK_W-1:0] feedbackCount = 8'h06;
	logic referenceIn = 1'b0;
	dpdc_pll_s pllConfig;
	logic referenceOut;
	logic averagedCalStart;
	logic averagedCalEnable;
	int err_total = 0;
	int checked = 0;
	logic [7:0] d;
	logic last;
	int n;
	always #12.5 clk = ~clk;
	dpdc_config_regs DUT (.clk(clk), .sys_rst(sys_rst), .regReq(regReq),
		.regRsp(regRsp), .feedbackCount(feedbackCount),
		.referenceIn(referenceIn), .pllConfig(pllConfig),
		.referenceOut(referenceOut), .averagedCalStart(averagedCalStart),
		.averagedCalEnable(averagedCalEnable));
	function automatic logic [4:0] oscR(logic [1:0] c);
		return (c == 2'h0) ? 5'h00 : 5'h01 << (c + 3'h1);
	endfunction : oscR
	function automatic logic [4:0] refR(logic [2:0] c);
		return (c > 3'h4) ? 5'h01 : 5'h01 << c;
	endfunction : refR
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	task automatic wr(logic [11:0] a, logic [7:0] v);
		@(posedge clk);
		regReq <= '{1'b1, 1'b0, a, v};
		@(posedge clk);
		regReq.wrEn <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(logic [11:0] a, logic [7:0] e);
		@(posedge clk);
		regReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		regReq.rdEn <= 1'b0;
		#1;
		chk(regRsp.rdValid, 1'b1);
		chk(regRsp.rdData, e);
	endtask : rd
	initial begin
		void'($urandom(32'h1421));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(PUMP_OFFSET, 8'h20);
		rd(OSC_OFFSET, 8'h02);
		rd(REF_OFFSET, 8'h01);
		rd(CAL_OFFSET, 8'h00);
		rd(12'h08D, 8'h00);
		chk(pllConfig.oscDivideRatio, 5'h08);
		$display("reset test done");
		// Random upper bits prove the reserved positions are dropped
		for (int i = 0; i < 16; i++) begin
			d = $urandom;
			// Frequencies are not modelled; codes only
			feedbackCount <= d;
			wr(PUMP_OFFSET, d ^ 8'hC5);
			wr(OSC_OFFSET, {d[7:2], i[1:0]});
			wr(REF_OFFSET, {d[7:3], i[2:0]});
			@(posedge clk);
			#1;
			chk(pllConfig.pumpCurrentCode, d[5:0] ^ 6'h05);
			chk(pllConfig.oscDivideRatio, oscR(i[1:0]));
			chk(pllConfig.oscDivideInvalid, i[1:0] == 2'h0);
			chk(pllConfig.referenceDivideInvalid, i[2:0] > 3'h4);
			chk(pllConfig.referenceDivideRatio, refR(i[2:0]));
			chk(pllConfig.converterMultiple, {d, 1'b0});
			chk(pllConfig.oscillatorMultiple, {d, 1'b0} * oscR(i[1:0]));
			rd(OSC_OFFSET, {6'h00, i[1:0]});
			rd(REF_OFFSET, {5'h00, i[2:0]});
		end
		wr(12'h08D, 8'hFF);
		rd(PUMP_OFFSET, {2'h0, d[5:0] ^ 6'h05});
		$display("field test done");
		// Enable goes first, and only a 0 to 1 trigger change starts
		wr(CAL_OFFSET, 8'h01);
		chk(averagedCalEnable, 1'b1);
		wr(CAL_OFFSET, 8'hFF);
		chk(averagedCalStart, 1'b1);
		rd(CAL_OFFSET, 8'h03);
		wr(CAL_OFFSET, 8'hFF);
		chk(averagedCalStart, 1'b0);
		wr(CAL_OFFSET, 8'h01);
		wr(CAL_OFFSET, 8'h03);
		chk(averagedCalStart, 1'b1);
		wr(CAL_OFFSET, 8'h00);
		chk(averagedCalEnable, 1'b0);
		$display("calibration test done");
		wr(REF_OFFSET, 8'h00);
		repeat (3) @(posedge clk);
		last = referenceIn;
		repeat (40) begin
			@(posedge clk);
			referenceIn <= $urandom;
			#1;
			chk(referenceOut, last);
			last = referenceIn;
		end
		$display("reference test done");
		referenceIn <= 1'b0;
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		rd(REF_OFFSET, 8'h01);
		// Reset ratio 2: every rising reference edge toggles the output
		last = referenceOut;
		n = 0;
		for (int k = 0; k < 19; k++) begin
			@(posedge clk);
			referenceIn <= (k < 16) ? ~k[0] : 1'b0;
			#1;
			if (referenceOut !== last) begin
				n++;
			end
			last = referenceOut;
		end
		chk(n, 16'h0008);
		$display("second reset test done");
		print_verdict();
	end
	initial begin
		#100000;
		err_total++;
		print_verdict();
	end
endmodule : dpdc_config_regs_bench
`default_nettype wire

// [tb/dpdc_props.sv]
`timescale 1ns/10ps
`default_nettype none
module dpdc_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire dpdc_pkg::dpdc_req_s regReq,
	input wire dpdc_pkg::dpdc_rsp_s regRsp,
	input wire logic [dpdc_pkg::FEEDBACK_W-1:0] feedbackCount,
	input wire logic referenceIn,
	input wire dpdc_pkg::dpdc_pll_s pllConfig,
	input wire logic referenceOut,
	input wire logic averagedCalStart,
	input wire logic averagedCalEnable
);
	import dpdc_pkg::*;
	logic calWr;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	function automatic logic [4:0] oscR(logic [1:0] c);
		return (c == 2'h0) ? 5'h00 : 5'h01 << (c + 3'h1);
	endfunction : oscR
	// A start pulse may only follow a write that set the trigger bit
	always_ff @(posedge clk) begin
		calWr <= regReq.wrEn && regReq.addr == CAL_OFFSET && regReq.wrData[1];
	end
	sequence wrAt(a);
		regReq.wrEn && regReq.addr == a;
	endsequence
	AST_RDV: assert property (regReq.rdEn |=> regRsp.rdValid)
		else $error("no read answer");
	AST_RSV: assert property (regReq.rdEn && regReq.addr == OSC_OFFSET
		|=> regRsp.rdData[7:2] == 6'h00) else $error("reserved bits set");
	AST_PUMP: assert property (wrAt(PUMP_OFFSET) |=> ##1
		pllConfig.pumpCurrentCode == $past(regReq.wrData[5:0], 2))
		else $error("pump code wrong");
	AST_OSC: assert property (wrAt(OSC_OFFSET) |=> ##1
		pllConfig.oscDivideRatio == oscR($past(regReq.wrData[1:0], 2)))
		else $error("osc ratio wrong");
	AST_REF: assert property (wrAt(REF_OFFSET) ##0
		regReq.wrData[2:0] <= REF_CODE_MAX |=> ##1 pllConfig.referenceDivideRatio
		== 5'h01 << $past(regReq.wrData[2:0], 2)) else $error("ref ratio wrong");
	AST_START: assert property (averagedCalStart |-> calWr)
		else $error("stray start pulse");
	AST_EN: assert property (wrAt(CAL_OFFSET) |=>
		averagedCalEnable == $past(regReq.wrData[0])) else $error("enable wrong");
	AST_MULT: assert property (!$past(sys_rst) |->
		pllConfig.converterMultiple == {$past(feedbackCount), 1'b0})
		else $error("multiple wrong");
endmodule : dpdc_props
bind dpdc_config_regs dpdc_props u_props (.clk(clk), .sys_rst(sys_rst),
	.regReq(regReq), .regRsp(regRsp), .feedbackCount(feedbackCount),
	.referenceIn(referenceIn), .pllConfig(pllConfig),
	.referenceOut(referenceOut), .averagedCalStart(averagedCalStart),
	.averagedCalEnable(averagedCalEnable));
`default_nettype wire
